//--- gdw_params.svh
// Constants for the GPIO-driven watchdog timer
`ifndef GDW_PARAMS_SVH
`define GDW_PARAMS_SVH
`define GDW_CLK_HZ 40000000
`define GDW_T100MS_MS 100
`define GDW_T1S_MS 1000
`define GDW_T10S_MS 10000
`define GDW_T1MIN_MS 60000
`define GDW_MS_CYC (`GDW_CLK_HZ / 1000)
`define GDW_OFS_DIR 8'h34
`define GDW_OFS_LVL 8'h38
`define GDW_BIT_EN 0
`define GDW_BIT_SLO 1
`define GDW_BIT_SHI 3
`define GDW_BIT_KICK 23
`define GDW_LVL_RST 32'h0000_0001
`define GDW_DIR_RST 32'h0000_0000
`define GDW_RST_PULSE 16
`endif

//--- gdw_pkg.sv
// Types for the GPIO-driven watchdog timer
`default_nettype none
package gdw_pkg;
  typedef enum logic [1:0] {GDW_OFF, GDW_RUN, GDW_FIRE} gdw_state_t;
  typedef struct packed {
    logic low_n;
    logic high_n;
    logic kick_n;
  } gdw_leds_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } gdw_io_req_t;
endpackage
`default_nettype wire

//--- gdw_top.sv
// GPIO-driven watchdog: level/direction registers, timer and reset output
//
// How it works
// - A high enable line keeps the watchdog off and the enable bit powers up at one.
// - Pulling the enable line low starts the watchdog with the period already selected.
// - Select lines high,low pick 100 ms (1,1), 1 s (1,0), 10 s (0,1) or 1 min (0,0).
// - If the period runs out without a kick the device asserts system reset.
// - Software toggles the kick line within the period and either edge counts as a kick.
// - After self test the low select, high select and kick levels show inverted on three LEDs.
`include "gdw_params.svh"
`timescale 1ns/100ps
`default_nettype none
module gdw_top #(
  parameter int unsigned T100MS_CYC = `GDW_T100MS_MS * `GDW_MS_CYC,
  parameter int unsigned T1S_CYC = `GDW_T1S_MS * `GDW_MS_CYC,
  parameter int unsigned T10S_CYC = `GDW_T10S_MS * `GDW_MS_CYC,
  parameter int unsigned T1MIN_CYC = `GDW_T1MIN_MS * `GDW_MS_CYC,
  parameter int unsigned RST_CYC = `GDW_RST_PULSE
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire gdw_pkg::gdw_io_req_t i_io,
  input wire logic i_post_done,
  output logic [31:0] o_rdata,
  output logic o_sys_rst,
  output gdw_pkg::gdw_leds_t o_leds
);
  import gdw_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] lvl;
    logic [31:0] dir;
    gdw_state_t st;
    logic [31:0] cnt;
    logic [31:0] limit;
    logic kick_q;
    logic [31:0] rdata;
    logic sys_rst;
    gdw_leds_t leds;
  } gdw_regs_t;

  gdw_regs_t r, next_r;

  logic en_n;
  logic sel_lo;
  logic sel_hi;
  logic kick;
  logic [31:0] period;

  assign en_n = r.lvl[`GDW_BIT_EN];
  assign sel_lo = r.lvl[`GDW_BIT_SLO];
  assign sel_hi = r.lvl[`GDW_BIT_SHI];
  assign kick = r.lvl[`GDW_BIT_KICK];

  // ----------------------------------------------------------------
  // Period decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case ({sel_hi, sel_lo})
      2'b11: period = T100MS_CYC;
      2'b10: period = T1S_CYC;
      2'b01: period = T10S_CYC;
      2'b00: period = T1MIN_CYC;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.kick_q = kick;
    // Register port; only the two documented words are mapped, others read zero
    if (i_io.wr && i_io.addr == `GDW_OFS_LVL) begin
      next_r.lvl = i_io.wdata;
    end
    if (i_io.wr && i_io.addr == `GDW_OFS_DIR) begin
      next_r.dir = i_io.wdata;
    end
    if (i_io.rd) begin
      unique case (i_io.addr)
        `GDW_OFS_LVL: next_r.rdata = r.lvl;
        `GDW_OFS_DIR: next_r.rdata = r.dir;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    unique case (r.st)
      GDW_OFF: begin
        next_r.sys_rst = 1'b0;
        next_r.cnt = 32'h0000_0000;
        if (!en_n) begin
          // The period is latched at start, so the select lines must settle first
          next_r.st = GDW_RUN;
          next_r.limit = period;
          next_r.cnt = 32'h0000_0000;
        end
      end
      GDW_RUN: begin
        if (en_n) begin
          next_r.st = GDW_OFF;
        end else if (kick != r.kick_q) begin
          next_r.cnt = 32'h0000_0000;
          next_r.limit = period;
        end else if (r.cnt >= r.limit - 32'h0000_0001) begin
          next_r.st = GDW_FIRE;
          next_r.cnt = 32'h0000_0000;
          next_r.sys_rst = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 32'h0000_0001;
        end
      end
      GDW_FIRE: begin
        // Fixed-width pulse; the system reset is expected to clear the level register
        next_r.sys_rst = 1'b1;
        next_r.cnt = r.cnt + 32'h0000_0001;
        if (r.cnt >= RST_CYC - 1) begin
          next_r.st = GDW_OFF;
          next_r.sys_rst = 1'b0;
          next_r.cnt = 32'h0000_0000;
        end
      end
      default: next_r.st = GDW_OFF;
    endcase
    if (i_post_done) begin
      // Active-low LED drive: a line at one leaves its LED dark, so the drive follows the bit
      next_r.leds.low_n = sel_lo;
      next_r.leds.high_n = sel_hi;
      next_r.leds.kick_n = kick;
    end else begin
      next_r.leds = '{low_n: 1'b0, high_n: 1'b0, kick_n: 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      r <= '0;
      r.lvl <= `GDW_LVL_RST;
      r.dir <= `GDW_DIR_RST;
      r.st <= GDW_OFF;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_sys_rst = r.sys_rst;
  assign o_leds = r.leds;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Enabled with no kick edge in this cycle, so the count must simply advance
  sequence s_enabled_quiet;
    !en_n && kick == r.kick_q;
  endsequence

  AST_DISABLED_NO_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_OFF && en_n) |=> !o_sys_rst)
    else $error("reset raised while disabled");
  AST_START_RUN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_OFF && !en_n) |=> (r.st == GDW_RUN && r.cnt == 32'h0000_0000))
    else $error("watchdog did not start");
  AST_PERIOD_LATCH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_OFF && !en_n) |=> (r.limit == $past(period)))
    else $error("wrong period latched");
  AST_EXPIRE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_RUN && !en_n && kick == r.kick_q && r.cnt >= r.limit - 32'h0000_0001)
      |=> (o_sys_rst && r.st == GDW_FIRE))
    else $error("expiry did not reset");
  AST_KICK_RESTART: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_RUN && !en_n && kick != r.kick_q) |=> (r.cnt == 32'h0000_0000 && !o_sys_rst))
    else $error("kick edge not honoured");
  AST_COUNT_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_RUN && r.cnt < r.limit - 32'h0000_0001) ##0 s_enabled_quiet
      |=> (r.cnt == $past(r.cnt) + 32'h0000_0001))
    else $error("count did not advance");
  AST_LED_MIRROR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_post_done |=> (o_leds.low_n == $past(sel_lo) && o_leds.kick_n == $past(kick)
      && o_leds.high_n == $past(sel_hi)))
    else $error("LED mirror wrong");
  AST_LVL_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_io.wr && i_io.addr == `GDW_OFS_LVL) |=> (r.lvl == $past(i_io.wdata)))
    else $error("level write lost");

  // ----------------------------------------------------------------
  // Checks: stopping, reset pulse, kick reload and register port
  // ----------------------------------------------------------------
  // Raising the enable line mid-count must abandon the count with no pulse
  sequence s_stop_request;
    r.st == GDW_RUN && en_n;
  endsequence

  AST_STOP_NOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_stop_request |=> (r.st == GDW_OFF && !o_sys_rst))
    else $error("watchdog kept running while disabled");
  AST_NO_EARLY_FIRE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_RUN && r.cnt < r.limit - 32'h0000_0001) |=> !o_sys_rst)
    else $error("reset raised before the period ran out");
  AST_PULSE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_FIRE && r.cnt < RST_CYC - 1) |=> (o_sys_rst && r.st == GDW_FIRE))
    else $error("reset pulse cut short");
  AST_PULSE_END: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_FIRE && r.cnt >= RST_CYC - 1) |=> (!o_sys_rst && r.st == GDW_OFF))
    else $error("reset pulse did not end");
  AST_KICK_RELOAD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == GDW_RUN && !en_n && kick != r.kick_q) |=> (r.limit == $past(period)))
    else $error("kick did not reload the period");
  AST_LVL_READ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_io.rd && i_io.addr == `GDW_OFS_LVL) |=> (o_rdata == $past(r.lvl)))
    else $error("level read wrong");
  AST_DIR_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_io.wr && i_io.addr == `GDW_OFS_DIR) |=> (r.dir == $past(i_io.wdata)))
    else $error("direction write lost");
endmodule // gdw_top
`default_nettype wire

//--- gdw_host_model.sv
// Host software model driving the watchdog's level and direction registers
`timescale 1ns/100ps
`default_nettype none
module gdw_host_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  output gdw_pkg::gdw_io_req_t o_io
);
  import gdw_pkg::*;
  logic [31:0] shadow = 32'h0000_0001;
  initial o_io = '0;
  // Offsets only: the base comes from bridge config space
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    o_io = '{a, 1'b1, 1'b0, d};
    @(negedge i_clk);
    o_io.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clk);
    o_io = '{a, 1'b0, 1'b1, 32'h0};
    @(negedge i_clk);
    o_io.rd = 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
  // Modify-write from a shadow copy, with no register read, so unrelated level bits never move
  task automatic set_lvl(input logic [31:0] m, input logic [31:0] v);
    shadow = (shadow & ~m) | v;
    wr(8'h38, shadow);
  endtask
endmodule // gdw_host_model
`default_nettype wire

//--- gpio_driven_watchdog_timer_tb_top.sv
// Testbench for the GPIO-driven watchdog
`timescale 1ns/100ps
`default_nettype none
module gpio_driven_watchdog_timer_tb_top;
  import gdw_pkg::*;
  // Shortened periods, indexed by {high select, low select}
  localparam int LIM[4] = '{160, 80, 40, 20};
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic post = 1'b0;
  gdw_io_req_t io;
  logic [31:0] rdata;
  logic sys_rst;
  gdw_leds_t leds;
  int n_errors = 0;
  int checked = 0;
  int fires = 0;
  always #12.5 i_clk = ~i_clk;
  always @(negedge i_clk) if (sys_rst === 1'b1) fires++;
  gdw_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_io(io));
  gdw_top #(.T100MS_CYC(20), .T1S_CYC(40), .T10S_CYC(80), .T1MIN_CYC(160), .RST_CYC(16)) uut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_io(io), .i_post_done(post),
    .o_rdata(rdata), .o_sys_rst(sys_rst), .o_leds(leds));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask
  // Bounded wait for the reset pulse, then its width
  task automatic wait_fire(input int lim);
    int n = 0;
    int w = 0;
    while (sys_rst !== 1'b1 && n < lim + 8) begin
      @(negedge i_clk);
      n++;
    end
    while (sys_rst === 1'b1 && w < 40) begin
      @(negedge i_clk);
      w++;
    end
    check(32'(n >= lim && n <= lim + 4), 32'h1);
    check(32'(w), 32'h10);
  endtask
  task automatic t_reset;
    rd_chk(8'h38, 32'h1);
    rd_chk(8'h34, 32'h0);
    rd_chk(8'h3c, 32'h0);
    check(32'(leds), 32'h0);
    host.wr(8'h34, 32'h0);
  endtask
  task automatic t_disabled;
    post = 1'b1;
    host.set_lvl(32'h0080_000a, 32'h0000_000a);
    fires = 0;
    repeat (200) @(negedge i_clk);
    check(32'(fires), 32'h0);
    check(32'(leds), 32'h6);
    rd_chk(8'h38, 32'h0000_000b);
  endtask
  task automatic t_periods;
    for (int s = 3; s >= 0; s--) begin
      host.set_lvl(32'ha, {28'h0, s[1], 1'b0, s[0], 1'b0});
      host.set_lvl(32'h1, 32'h0);
      wait_fire(LIM[s]);
      check(32'(leds), {29'h0, s[0], s[1], 1'b0});
      host.set_lvl(32'h1, 32'h1);
    end
  endtask
  // Both kick edges keep it alive; silence then fires one period on
  task automatic t_kick;
    host.set_lvl(32'hb, 32'hb);
    host.set_lvl(32'h1, 32'h0);
    fires = 0;
    repeat (6) begin
      repeat (10) @(negedge i_clk);
      host.set_lvl(32'h0080_0000, ~host.shadow & 32'h0080_0000);
    end
    check(32'(fires), 32'h0);
    wait_fire(20);
    host.set_lvl(32'h1, 32'h1);
  endtask
  // Disabling mid-count, then a reset mid-run, must both end the count with no pulse
  task automatic t_stop;
    host.set_lvl(32'ha, 32'h0);
    host.set_lvl(32'h1, 32'h0);
    repeat (100) @(negedge i_clk);
    fires = 0;
    host.set_lvl(32'h1, 32'h1);
    repeat (200) @(negedge i_clk);
    check(32'(fires), 32'h0);
    host.set_lvl(32'h1, 32'h0);
    repeat (100) @(negedge i_clk);
    i_rst_b = 1'b0;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    host.shadow = 32'h0000_0001;
    fires = 0;
    repeat (200) @(negedge i_clk);
    check(32'(fires), 32'h0);
    rd_chk(8'h38, 32'h1);
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_reset();
    t_disabled();
    t_periods();
    t_kick();
    t_stop();
    give_verdict();
  end
endmodule // gpio_driven_watchdog_timer_tb_top
`default_nettype wire
